// *** hw/ehr_pkg.sv ***
/*
 Shared constants and types of the entropy hash random buffer.
 Assumes a single 50 MHz core clock domain.
*/
// What this block does
// R1: XOR 125 oscillator jitter bits into a 128-bit LFSR mixer.
// R2: Mixer accumulates 81 cycles; hash engine starts once per 81 cycles.
// R3: Hash words 1-4 are LFSR words low to high, sampled together.
// R4: Words 5-9 prior digest a-e; then 0x80000000, five zeros, 0x120.
// R5: Hash 512-bit block from 160-bit IV; push digest's first 64 bits.
// R6: Raw mode picks one byte group, shifts it, 64-bit word per 8 cycles.
// R7: Group code n selects oscillator bits 8n to 8n+7.
// R8: Export bit selects raw shift word or hash digest as FIFO source.
// R9: 512-byte FIFO of eight-byte entries, refilled continuously.
// R10: Every load pops one entry; narrow loads get the low bytes.
// R11: Entropy enable resets to zero; cleared gives predictable output; raw export words still carry oscillator bytes.
// R12: Generator disabled: no delivery, FIFO cleared, LFSR held at one.
// R13: Entropy off: deterministic fill after generator enable rises; raw export mode still fills with oscillator bytes.
// R14: Block transfer of 1-255 words returns that many entries.
// R15: Soft resets clear generator, or buffer logic but not registers.
// R16: Self-test status: bit 1 first memory, bit 0 second; one failed.
// R17: Empty FIFO stalls the answer instead of returning stale data.
// R18: Hash is the SHA-1 compression with standard chaining values.
// R19: Software reaches the registers through the shared I/O bus path.
package ehr_pkg;
	localparam int OSC_N      = 128;
	localparam int ENT_N      = 125;
	localparam int WORD_W     = 64;
	localparam int GRP_W      = 8;
	localparam int SEL_W      = 4;
	localparam int FIFO_DEPTH = 64;
	localparam int LEN_W      = 8;
	localparam logic [6:0] HASH_LAST  = 7'h50;
	localparam logic [6:0] ROUND_LAST = 7'h4f;
	localparam logic [6:0] STAGE1     = 7'h14;
	localparam logic [6:0] STAGE2     = 7'h28;
	localparam logic [6:0] STAGE3     = 7'h3c;
	localparam logic [2:0] RAW_LAST   = 3'h7;
	localparam logic [127:0] LFSR_RST  = 128'h1;
	localparam logic [127:0] LFSR_TAPS = {1'b1, 1'b0, 1'b1, 24'h0, 1'b1, 1'b0, 1'b1, 98'h0};
	localparam logic [31:0] PAD_ONE = 32'h80000000;
	localparam logic [31:0] PAD_LEN = 32'h00000120;
	localparam logic [159:0] SHA_IV = {32'hc3d2e1f0, 32'h10325476, 32'h98badcfe,
		32'hefcdab89, 32'h67452301};
	localparam logic [31:0] K0 = 32'h5a827999;
	localparam logic [31:0] K1 = 32'h6ed9eba1;
	localparam logic [31:0] K2 = 32'h8f1bbcdc;
	localparam logic [31:0] K3 = 32'hca62c1d6;
	localparam logic [63:0] ADDR_CTL  = 64'h0001180040000000;
	localparam logic [63:0] ADDR_BIST = 64'h0000118004000008;
	localparam int CTL_ENTROPY_SOURCE_ENABLE = 0;
	localparam int CTL_GEN_EN = 1;
	localparam int CTL_BUF_RST = 2;
	localparam int CTL_GEN_RST = 3;
	localparam int CTL_EXPORT = 4;
	localparam int CTL_SEL_LO = 5;
	localparam int CTL_W      = 9;
	localparam logic [CTL_W-1:0] CTL_RST = 9'h000;
	localparam int BIST_FIRST  = 1;
	localparam int BIST_SECOND = 0;
	localparam logic [1:0] SZ_8  = 2'h0;
	localparam logic [1:0] SZ_16 = 2'h1;
	localparam logic [1:0] SZ_32 = 2'h2;
	typedef enum logic [1:0] {
		SVC_IDLE = 2'b00,
		SVC_LOAD = 2'b01,
		SVC_DMA  = 2'b10
	} ehr_svc_t;
endpackage

// *** hw/ehr_mem_if.sv ***
/*
 Port bundle between the buffer control and its entry memory.
 Assumes both ends share the core clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface ehr_mem_if #(parameter int W = 64, parameter int AW = 6);
	logic          wr_en;
	logic [AW-1:0] wr_addr;
	logic [W-1:0]  wr_data;
	logic          rd_en;
	logic [AW-1:0] rd_addr;
	logic [W-1:0]  rd_data;
	modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
	modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface
`default_nettype wire

// *** hw/ehr_fifo_mem.sv ***
/*
 Entry memory of the random FIFO, registered read data.
 Assumes the controller never reads and writes one entry in one cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module ehr_fifo_mem #(
	parameter int W     = 64,
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	input  wire logic clk_sys_i,
	input  wire logic ce_i,
	ehr_mem_if.mem    m
);
	logic [W-1:0] store_q [DEPTH];
	logic [W-1:0] rd_data_ff;

	always_ff @(posedge clk_sys_i)
	begin
		if (ce_i)
		begin
			if (m.wr_en)
				store_q[m.wr_addr] <= m.wr_data;
			if (m.rd_en)
				rd_data_ff <= store_q[m.rd_addr];
		end
	end

	assign m.rd_data = rd_data_ff;
endmodule
`default_nettype wire

// *** hw/ehr_top.sv ***
/*
 Random unit: oscillator mixer, SHA-1 whitener, raw path, FIFO and
 core answer logic. Assumes core requests and register accesses come
 from logic on clk_sys_i; oscillator and self-test inputs are async.
*/
`timescale 1ns/1ns
`default_nettype none
module ehr_top
	import ehr_pkg::*;
#(
	parameter int DEPTH = ehr_pkg::FIFO_DEPTH
) (
	input  wire logic                      clk_sys_i,
	input  wire logic                      rst_b_i,
	input  wire logic                      ce_i,
	input  wire logic [ehr_pkg::OSC_N-1:0] osc_i,
	input  wire logic                      bist_first_fail_i,
	input  wire logic                      bist_second_fail_i,
	input  wire logic                      csr_wr_i,
	input  wire logic                      csr_rd_i,
	input  wire logic [63:0]               csr_addr_i,
	input  wire logic [63:0]               csr_wdata_i,
	output logic      [63:0]               csr_rdata_o,
	output logic                           csr_rvalid_o,
	input  wire logic                      ld_req_i,
	input  wire logic [1:0]                ld_size_i,
	input  wire logic                      dma_req_i,
	input  wire logic [ehr_pkg::LEN_W-1:0] dma_len_i,
	input  wire logic [7:0]                dma_scraddr_i,
	output logic                           req_rdy_o,
	output logic                           ld_valid_o,
	output logic      [63:0]               ld_data_o,
	output logic                           dma_valid_o,
	output logic      [7:0]                dma_addr_o,
	output logic      [63:0]               dma_data_o
);
	import ehr_pkg::*;
	localparam int AW = $clog2(DEPTH);

	// ****************************************************************
	// Input synchronisers and registers
	// ****************************************************************
	logic [OSC_N-1:0] osc_m_ff, osc_ff;
	logic [1:0]       bist_m_ff, bist_ff;
	logic [CTL_W-1:0] ctl_ff;
	logic [63:0]      csr_rdata_ff;
	logic             csr_rvalid_ff;

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			osc_m_ff  <= '0;
			osc_ff    <= '0;
			bist_m_ff <= '0;
			bist_ff   <= '0;
		end
		else if (ce_i)
		begin
			osc_m_ff  <= osc_i;
			osc_ff    <= osc_m_ff;
			bist_m_ff <= {bist_first_fail_i, bist_second_fail_i};
			bist_ff   <= bist_m_ff;
		end
	end

	wire entropy_source_enable  = ctl_ff[CTL_ENTROPY_SOURCE_ENABLE];
	wire gen_en  = ctl_ff[CTL_GEN_EN];
	wire buf_rst = ctl_ff[CTL_BUF_RST];
	wire gen_rst = ctl_ff[CTL_GEN_RST];
	wire export_raw = ctl_ff[CTL_EXPORT];
	wire [SEL_W-1:0] grp_sel = ctl_ff[CTL_SEL_LO +: SEL_W];
	// Generator held cleared while disabled or in generator soft reset
	wire gen_clr = !gen_en || gen_rst; // R12 R15
	wire buf_clr = !gen_en || buf_rst || gen_rst; // R12 R15

	wire hit_ctl  = csr_addr_i == ADDR_CTL;
	wire hit_bist = csr_addr_i == ADDR_BIST;
	wire [63:0] ctl_rd  = {{(64-CTL_W){1'b0}}, ctl_ff};
	wire [63:0] bist_rd = {62'h0, bist_ff[1], bist_ff[0]}; // R16
	wire [63:0] csr_mux = hit_ctl ? ctl_rd : (hit_bist ? bist_rd : 64'h0);

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ctl_ff        <= CTL_RST; // R11
			csr_rdata_ff  <= '0;
			csr_rvalid_ff <= 1'b0;
		end
		else if (ce_i)
		begin
			if (csr_wr_i && hit_ctl)
				ctl_ff <= csr_wdata_i[CTL_W-1:0];
			csr_rvalid_ff <= csr_rd_i;
			if (csr_rd_i)
				csr_rdata_ff <= csr_mux;
		end
	end

	// ****************************************************************
	// Entropy mixer and raw byte path
	// ****************************************************************
	logic [127:0] lfsr_ff;
	logic [6:0]   per_ff;
	logic [63:0]  raw_ff;
	logic [2:0]   raw_cnt_ff;

	wire         lfsr_fb  = ^(lfsr_ff & LFSR_TAPS);
	wire [127:0] ent_mix  = entropy_source_enable ? {{(128-ENT_N){1'b0}}, osc_ff[ENT_N-1:0]} : 128'h0; // R1 R11
	wire [127:0] nxt_lfsr = {lfsr_ff[126:0], lfsr_fb} ^ ent_mix; // R1
	wire         hash_go  = per_ff == HASH_LAST; // R2
	wire [GRP_W-1:0] grp  = osc_ff[grp_sel*GRP_W +: GRP_W]; // R7
	wire [63:0]  raw_word = {raw_ff[55:0], grp}; // R6
	wire         raw_full = raw_cnt_ff == RAW_LAST;

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			lfsr_ff    <= LFSR_RST;
			per_ff     <= '0;
			raw_ff     <= '0;
			raw_cnt_ff <= '0;
		end
		else if (ce_i)
		begin
			if (gen_clr)
			begin
				lfsr_ff    <= LFSR_RST; // R12
				per_ff     <= '0;
				raw_ff     <= '0;
				raw_cnt_ff <= '0;
			end
			else
			begin
				lfsr_ff    <= nxt_lfsr;
				per_ff     <= hash_go ? 7'h0 : per_ff + 7'h1; // R2
				raw_ff     <= raw_word; // R6
				raw_cnt_ff <= raw_cnt_ff + 3'h1;
			end
		end
	end

	// ****************************************************************
	// SHA-1 engine, one round per cycle
	// ****************************************************************
	logic [159:0] st_ff;
	logic [159:0] dig_ff;
	logic [511:0] ws_ff;
	logic [6:0]   rnd_ff;
	logic         run_ff;

	wire [31:0] sa = st_ff[31:0];
	wire [31:0] sb = st_ff[63:32];
	wire [31:0] sc = st_ff[95:64];
	wire [31:0] sd = st_ff[127:96];
	wire [31:0] se = st_ff[159:128];
	wire [31:0] f_ch  = (sb & sc) | (~sb & sd);
	wire [31:0] f_par = sb ^ sc ^ sd;
	wire [31:0] f_maj = (sb & sc) | (sb & sd) | (sc & sd);
	wire [31:0] f_sel = rnd_ff < STAGE1 ? f_ch :
		(rnd_ff < STAGE2 ? f_par : (rnd_ff < STAGE3 ? f_maj : f_par));
	wire [31:0] k_sel = rnd_ff < STAGE1 ? K0 :
		(rnd_ff < STAGE2 ? K1 : (rnd_ff < STAGE3 ? K2 : K3));
	wire [31:0] tmp = {sa[26:0], sa[31:27]} + f_sel + se + k_sel + ws_ff[31:0]; // R18
	wire [31:0] wx  = ws_ff[447:416] ^ ws_ff[287:256] ^ ws_ff[95:64] ^ ws_ff[31:0];
	wire [159:0] nxt_st = {sd, sc, {sb[1:0], sb[31:2]}, sa, tmp};
	wire [159:0] nxt_dig = {SHA_IV[159:128] + nxt_st[159:128],
		SHA_IV[127:96] + nxt_st[127:96], SHA_IV[95:64] + nxt_st[95:64],
		SHA_IV[63:32] + nxt_st[63:32], SHA_IV[31:0] + nxt_st[31:0]}; // R18
	// Block: LFSR words, previous digest, padding
	wire [511:0] blk = {PAD_LEN, 160'h0, PAD_ONE, dig_ff, lfsr_ff}; // R3 R4
	wire hash_end = run_ff && rnd_ff == ROUND_LAST;

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			st_ff  <= '0;
			dig_ff <= SHA_IV;
			ws_ff  <= '0;
			rnd_ff <= '0;
			run_ff <= 1'b0;
		end
		else if (ce_i)
		begin
			if (gen_clr)
			begin
				dig_ff <= SHA_IV; // R13
				run_ff <= 1'b0;
				rnd_ff <= '0;
			end
			else if (hash_go)
			begin
				st_ff  <= SHA_IV; // R5
				ws_ff  <= blk; // R3
				rnd_ff <= '0;
				run_ff <= 1'b1;
			end
			else if (run_ff)
			begin
				st_ff  <= nxt_st;
				ws_ff  <= {wx[30:0], wx[31], ws_ff[511:32]};
				rnd_ff <= rnd_ff + 7'h1;
				if (hash_end)
				begin
					run_ff <= 1'b0;
					dig_ff <= nxt_dig; // R4
				end
			end
		end
	end

	// ****************************************************************
	// FIFO fill
	// ****************************************************************
	logic          push_ff;
	logic [63:0]   push_word_ff;
	logic [AW:0]   fcnt_ff;
	logic [AW-1:0] wp_ff, rp_ff;

	wire        nxt_push = !gen_clr && (export_raw ? raw_full : hash_end); // R8 R6
	wire [63:0] nxt_push_word = export_raw ? raw_word : nxt_dig[63:0]; // R8 R5
	wire fifo_empty = fcnt_ff == '0;
	wire fifo_full  = fcnt_ff == (AW+1)'(DEPTH);
	// Words arriving while full are dropped; fresh ones follow anyway
	wire fifo_wr = push_ff && !fifo_full && !buf_clr; // R9

	// ****************************************************************
	// Two-entry output buffer and memory reads
	// ****************************************************************
	logic [63:0] ob_ff [2];
	logic        ob_wp_ff, ob_rp_ff, inflight_ff;
	logic [1:0]  ob_cnt_ff;
	ehr_svc_t    svc_ff;

	wire ob_valid = ob_cnt_ff != 2'h0;
	// Reads stall while the buffer cannot take the word in flight
	wire ob_room  = ({1'b0, ob_cnt_ff} + {2'h0, inflight_ff}) < 3'h2;
	wire fifo_rd  = !fifo_empty && ob_room && !buf_clr; // R17
	wire serving  = svc_ff != SVC_IDLE;
	// No answer while the buffer is being cleared or the generator is off
	wire ob_pop   = serving && ob_valid && !buf_clr; // R10 R12 R17
	wire ob_push  = inflight_ff && !buf_clr;

	ehr_mem_if #(.W(WORD_W), .AW(AW)) mem_bus ();
	assign mem_bus.wr_en   = fifo_wr && ce_i;
	assign mem_bus.wr_addr = wp_ff;
	assign mem_bus.wr_data = push_word_ff;
	assign mem_bus.rd_en   = fifo_rd && ce_i;
	assign mem_bus.rd_addr = rp_ff;

	ehr_fifo_mem #(.W(WORD_W), .DEPTH(DEPTH), .AW(AW)) u_mem (
		.clk_sys_i (clk_sys_i),
		.ce_i      (ce_i),
		.m         (mem_bus)
	);

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			push_ff      <= 1'b0;
			push_word_ff <= '0;
			fcnt_ff      <= '0;
			wp_ff        <= '0;
			rp_ff        <= '0;
			inflight_ff  <= 1'b0;
			ob_wp_ff     <= 1'b0;
			ob_rp_ff     <= 1'b0;
			ob_cnt_ff    <= '0;
			ob_ff[0]     <= '0;
			ob_ff[1]     <= '0;
		end
		else if (ce_i)
		begin
			push_ff      <= nxt_push;
			push_word_ff <= nxt_push_word;
			if (buf_clr)
			begin
				fcnt_ff     <= '0; // R12 R15
				wp_ff       <= '0;
				rp_ff       <= '0;
				inflight_ff <= 1'b0;
				ob_wp_ff    <= 1'b0;
				ob_rp_ff    <= 1'b0;
				ob_cnt_ff   <= '0;
			end
			else
			begin
				fcnt_ff     <= fcnt_ff + (AW+1)'(fifo_wr) - (AW+1)'(fifo_rd); // R9
				wp_ff       <= wp_ff + AW'(fifo_wr);
				rp_ff       <= rp_ff + AW'(fifo_rd);
				inflight_ff <= fifo_rd;
				if (ob_push)
					ob_ff[ob_wp_ff] <= mem_bus.rd_data;
				ob_wp_ff  <= ob_wp_ff ^ ob_push;
				ob_rp_ff  <= ob_rp_ff ^ ob_pop;
				ob_cnt_ff <= ob_cnt_ff + 2'(ob_push) - 2'(ob_pop);
			end
		end
	end

	// ****************************************************************
	// Core load and block transfer answers
	// ****************************************************************
	logic [1:0]       size_ff;
	logic [LEN_W-1:0] left_ff;
	logic [7:0]       addr_ff;
	logic             rdy_ff, ld_valid_ff, dma_valid_ff;
	logic [63:0]      ld_data_ff, dma_data_ff;
	logic [7:0]       dma_addr_ff;

	wire [63:0] head = ob_ff[ob_rp_ff];
	wire [63:0] ld_word = size_ff == SZ_8 ? {56'h0, head[7:0]} :
		(size_ff == SZ_16 ? {48'h0, head[15:0]} :
		(size_ff == SZ_32 ? {32'h0, head[31:0]} : head)); // R10
	wire take_ld  = rdy_ff && ld_req_i;
	wire take_dma = rdy_ff && !ld_req_i && dma_req_i && dma_len_i != '0; // R14
	wire dma_last = left_ff == LEN_W'(1);

	ehr_svc_t nxt_svc;
	always_comb
	begin
		nxt_svc = svc_ff;
		unique case (svc_ff)
			SVC_IDLE:
				if (take_ld)
					nxt_svc = SVC_LOAD;
				else if (take_dma)
					nxt_svc = SVC_DMA;
			SVC_LOAD:
				if (ob_pop)
					nxt_svc = SVC_IDLE;
			SVC_DMA:
				if (ob_pop && dma_last)
					nxt_svc = SVC_IDLE;
			default:
				nxt_svc = SVC_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			svc_ff       <= SVC_IDLE;
			rdy_ff       <= 1'b0;
			size_ff      <= '0;
			left_ff      <= '0;
			addr_ff      <= '0;
			ld_valid_ff  <= 1'b0;
			dma_valid_ff <= 1'b0;
			ld_data_ff   <= '0;
			dma_data_ff  <= '0;
			dma_addr_ff  <= '0;
		end
		else if (ce_i)
		begin
			svc_ff       <= buf_rst ? SVC_IDLE : nxt_svc; // R15
			rdy_ff       <= !buf_rst && nxt_svc == SVC_IDLE;
			ld_valid_ff  <= ob_pop && svc_ff == SVC_LOAD; // R10
			dma_valid_ff <= ob_pop && svc_ff == SVC_DMA; // R14
			if (take_ld)
				size_ff <= ld_size_i;
			if (take_dma)
			begin
				left_ff <= dma_len_i;
				addr_ff <= dma_scraddr_i;
			end
			if (ob_pop && svc_ff == SVC_LOAD)
				ld_data_ff <= ld_word;
			if (ob_pop && svc_ff == SVC_DMA)
			begin
				dma_data_ff <= head; // R14
				dma_addr_ff <= addr_ff;
				addr_ff     <= addr_ff + 8'h1;
				left_ff     <= left_ff - LEN_W'(1);
			end
		end
	end

	assign csr_rdata_o  = csr_rdata_ff;
	assign csr_rvalid_o = csr_rvalid_ff;
	assign req_rdy_o    = rdy_ff;
	assign ld_valid_o   = ld_valid_ff;
	assign ld_data_o    = ld_data_ff;
	assign dma_valid_o  = dma_valid_ff;
	assign dma_addr_o   = dma_addr_ff;
	assign dma_data_o   = dma_data_ff;
endmodule
`default_nettype wire

// *** sim/ehr_properties.sv ***
/*
 Checker of the random unit's port behaviour, bound to ehr_top.
 Assumes one clock domain and the core-side contract of ehr_top.
*/
`timescale 1ns/1ns
`default_nettype none
module ehr_chk
	import ehr_pkg::*;
(
	input wire logic        clk_sys_i,
	input wire logic        rst_b_i,
	input wire logic        ce_i,
	input wire logic        csr_rd_i,
	input wire logic [63:0] csr_addr_i,
	input wire logic [63:0] csr_rdata_o,
	input wire logic        csr_rvalid_o,
	input wire logic        ld_req_i,
	input wire logic [1:0]  ld_size_i,
	input wire logic        req_rdy_o,
	input wire logic        ld_valid_o,
	input wire logic [63:0] ld_data_o,
	input wire logic        dma_valid_o,
	input wire logic [7:0]  dma_addr_o
);
	logic [1:0]  sz_ff;
	logic [63:0] keep_w;
	// ****
	// Size of the load in flight
	// ****
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			sz_ff <= 2'h0;
		else if (ld_req_i && req_rdy_o && ce_i)
			sz_ff <= ld_size_i;
	end
	assign keep_w = (sz_ff == 2'h3) ? '1 : (64'h1 << (8 << sz_ff)) - 64'h1;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	a_read_gets_answer: assert property (csr_rd_i && ce_i |=> csr_rvalid_o)
		else $error("read got no answer");
	a_answer_has_read: assert property (csr_rvalid_o && $past(ce_i) |-> $past(csr_rd_i))
		else $error("answer without read");
	a_unmapped_reads_zero: assert property (csr_rd_i && ce_i && csr_addr_i != ADDR_CTL
		&& csr_addr_i != ADDR_BIST |=> csr_rdata_o == 64'h0) else $error("unmapped not zero");
	a_selftest_spare_zero: assert property (csr_rd_i && ce_i && csr_addr_i == ADDR_BIST
		|=> csr_rdata_o[63:2] == 62'h0) else $error("self-test spare bits set");
	a_control_spare_zero: assert property (csr_rd_i && ce_i && csr_addr_i == ADDR_CTL
		|=> csr_rdata_o[63:9] == 55'h0) else $error("control spare bits set");
	a_load_min_latency: assert property (ld_req_i && req_rdy_o && ce_i
		|=> !ld_valid_o && !req_rdy_o) else $error("load answered too soon");
	a_load_one_pulse: assert property (ld_valid_o |=> !ld_valid_o)
		else $error("load answer too long");
	a_narrow_load_bytes: assert property (ld_valid_o |-> (ld_data_o & ~keep_w) == 64'h0)
		else $error("narrow load upper bytes set");
	a_dma_addr_step: assert property (dma_valid_o ##1 dma_valid_o
		|-> dma_addr_o == $past(dma_addr_o) + 8'h1) else $error("transfer address skipped");
	a_ready_with_answer: assert property (ld_valid_o |-> req_rdy_o)
		else $error("not ready after answer");
endmodule
bind ehr_top ehr_chk chk_u (.*);
`default_nettype wire

// *** sim/ehr_core_model.sv ***
/*
 Core model: issues loads and block transfers, collects answers.
 Assumes requests are driven at the falling clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module ehr_core_model (
	input  wire logic        clk_sys_i,
	input  wire logic        req_rdy_i,
	input  wire logic        ld_valid_i,
	input  wire logic [63:0] ld_data_i,
	input  wire logic        dma_valid_i,
	input  wire logic [7:0]  dma_addr_i,
	input  wire logic [63:0] dma_data_i,
	output var  logic        ld_req_o,
	output var  logic [1:0]  ld_size_o,
	output var  logic        dma_req_o,
	output var  logic [7:0]  dma_len_o,
	output var  logic [7:0]  dma_scraddr_o
);
	int          ld_cnt = 0;
	logic [63:0] ld_d;
	logic [63:0] dq[$];
	logic [7:0]  aq[$];
	initial
	begin
		ld_req_o = 1'b0;
		ld_size_o = 2'h0;
		dma_req_o = 1'b0;
		dma_len_o = 8'h0;
		dma_scraddr_o = 8'h0;
	end
	always @(posedge clk_sys_i)
	begin
		if (ld_valid_i === 1'b1)
		begin
			ld_cnt++;
			ld_d = ld_data_i;
		end
		if (dma_valid_i === 1'b1)
		begin
			dq.push_back(dma_data_i);
			aq.push_back(dma_addr_i);
		end
	end
	// ****
	// Requests are held until taken; answers are awaited for at most 3000 cycles
	// ****
	task automatic load(input logic [1:0] s, output logic [63:0] d);
		int c0;
		int n;
		c0 = ld_cnt;
		n = 0;
		@(negedge clk_sys_i);
		ld_req_o = 1'b1;
		ld_size_o = s;
		while (req_rdy_i !== 1'b1) @(negedge clk_sys_i);
		@(negedge clk_sys_i);
		ld_req_o = 1'b0;
		ld_size_o = ~s;
		while (ld_cnt == c0 && n < 3000) begin @(negedge clk_sys_i); n++; end
		d = (ld_cnt == c0) ? 'x : ld_d;
	endtask
	task automatic dma(input logic [7:0] len, input logic [7:0] a);
		int n;
		n = 0;
		dq.delete();
		aq.delete();
		@(negedge clk_sys_i);
		dma_req_o = 1'b1;
		dma_len_o = len;
		dma_scraddr_o = a;
		while (req_rdy_i !== 1'b1) @(negedge clk_sys_i);
		@(negedge clk_sys_i);
		dma_req_o = 1'b0;
		dma_len_o = ~len;
		dma_scraddr_o = ~a;
		while (dq.size() < len && n < 3000) begin @(negedge clk_sys_i); n++; end
	endtask
endmodule
`default_nettype wire

// *** sim/tb_ehr_top.sv ***
/*
 Self-checking bench of ehr_top with a core model on its load side.
 Assumes a 50 MHz clock and a shortened FIFO depth of eight.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_ehr_top;
	import ehr_pkg::*;
	logic         clk_sys_i, rst_b_i, ce_i, csr_wr_i, csr_rd_i, csr_rvalid_o, hold;
	logic         bist_first_fail_i, bist_second_fail_i, ld_req_i, dma_req_i;
	logic         req_rdy_o, ld_valid_o, dma_valid_o;
	logic [127:0] osc_i, osc_set;
	logic [63:0]  csr_addr_i, csr_wdata_i, csr_rdata_o, ld_data_o, dma_data_o, rd, d;
	logic [63:0]  rf[4];
	logic [1:0]   ld_size_i, s;
	logic [7:0]   dma_len_i, dma_scraddr_i, dma_addr_o, v;
	integer       seed, error_cnt, checks_done, cyc;
	ehr_top #(.DEPTH(8)) dut_u (.*);
	ehr_core_model core_u (.clk_sys_i(clk_sys_i), .req_rdy_i(req_rdy_o),
		.ld_valid_i(ld_valid_o), .ld_data_i(ld_data_o), .dma_valid_i(dma_valid_o),
		.dma_addr_i(dma_addr_o), .dma_data_i(dma_data_o), .ld_req_o(ld_req_i),
		.ld_size_o(ld_size_i), .dma_req_o(dma_req_i), .dma_len_o(dma_len_i),
		.dma_scraddr_o(dma_scraddr_i));
	initial
	begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	function automatic logic [127:0] rnd128();
		return {$random(seed), $random(seed), $random(seed), $random(seed)};
	endfunction
	function automatic logic [63:0] msk(input logic [1:0] z);
		return (z == 2'h3) ? '1 : (64'h1 << (8 << z)) - 64'h1;
	endfunction
	task automatic chk(input logic [63:0] g, e, input string nm);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic csr_w(input logic [63:0] a, dt);
		@(negedge clk_sys_i);
		csr_wr_i = 1'b1;
		csr_addr_i = a;
		csr_wdata_i = dt;
		@(negedge clk_sys_i);
		csr_wr_i = 1'b0;
		csr_addr_i = ~a;
		csr_wdata_i = ~dt;
	endtask
	task automatic csr_r(input logic [63:0] a, output logic [63:0] q);
		@(negedge clk_sys_i);
		csr_rd_i = 1'b1;
		csr_addr_i = a;
		@(negedge clk_sys_i);
		csr_rd_i = 1'b0;
		csr_addr_i = ~a;
		chk(csr_rvalid_o, 64'h1, "read answer");
		q = csr_rdata_o;
	endtask
	// ****
	// Free-running oscillators unless a scenario holds them
	// ****
	always @(negedge clk_sys_i)
		osc_i <= hold ? osc_set : rnd128();
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			error_cnt++;
			print_verdict();
		end
	end
	initial
	begin
		seed = 32'hbe0a;
		{error_cnt, checks_done, cyc} = '0;
		{hold, rst_b_i, csr_wr_i, csr_rd_i, csr_addr_i, csr_wdata_i, osc_set} = '0;
		ce_i = 1'b1;
		bist_first_fail_i = 1'($random(seed));
		bist_second_fail_i = 1'($random(seed));
		repeat (20) @(negedge clk_sys_i);
		rst_b_i = 1'b1;
		repeat (2) @(negedge clk_sys_i);
		chk(req_rdy_o, 64'h1, "ready");
		csr_r(ADDR_CTL, rd);
		chk(rd, 64'h0, "control reset");
		d = {$random(seed), $random(seed)} & ~64'hf;
		csr_w(ADDR_CTL, d);
		csr_r(ADDR_CTL, rd);
		chk(rd, {55'h0, d[8:0]}, "control");
		csr_w(ADDR_BIST, '1);
		csr_w(ADDR_CTL + 64'h10, '1);
		csr_r(ADDR_CTL + 64'h10, rd);
		chk(rd, 64'h0, "unmapped");
		csr_r(ADDR_BIST, rd);
		chk(rd, {62'h0, bist_first_fail_i, bist_second_fail_i}, "self-test");
		// Entropy off: the reference sequence, replayed below
		csr_w(ADDR_CTL, 64'h2);
		for (int i = 0; i < 4; i++) core_u.load(2'h3, rf[i]);
		chk(rf[0] !== rf[1], 64'h1, "fresh word");
		csr_w(ADDR_CTL, 64'h0);
		s = 2'($random(seed));
		fork
			core_u.load(s, d);
			begin
				repeat (300) @(negedge clk_sys_i);
				chk(core_u.ld_cnt, 64'h4, "stalled load");
				csr_w(ADDR_CTL, 64'h2);
			end
		join
		chk(d, rf[0] & msk(s), "replayed word");
		s = 2'($random(seed));
		core_u.load(s, d);
		chk(d, rf[1] & msk(s), "next word");
		core_u.dma(8'h2, 8'hff);
		chk(core_u.dq[0], rf[2], "transfer word");
		chk(core_u.dq[1], rf[3], "transfer word");
		chk(core_u.aq[0], 64'hff, "transfer address");
		chk(core_u.aq[1], 64'h0, "transfer address");
		csr_w(ADDR_CTL, 64'he);
		csr_w(ADDR_CTL, 64'h2);
		core_u.load(2'h3, d);
		chk(d, rf[0], "after soft reset");
		csr_w(ADDR_CTL, 64'h0);
		csr_w(ADDR_CTL, 64'h3);
		core_u.load(2'h3, d);
		chk(d !== rf[0], 64'h1, "entropy word");
		// Frozen clock enable: a write in that time must not land
		ce_i = 1'b0;
		csr_w(ADDR_CTL, 64'h0);
		ce_i = 1'b1;
		csr_r(ADDR_CTL, rd);
		chk(rd, 64'h3, "frozen control");
		for (int n = 0; n < 16; n++)
		begin
			v = 8'($random(seed));
			osc_set = rnd128() & ~(128'hff << (8 * n)) | (128'(v) << (8 * n));
			hold = 1'b1;
			csr_w(ADDR_CTL, 64'h0);
			csr_w(ADDR_CTL, 64'h12 | (n << 5));
			repeat (2) core_u.load(2'h3, d);
			s = 2'($random(seed));
			core_u.load(s, d);
			chk(d, {8{v}} & msk(s), "raw word");
		end
		print_verdict();
	end
endmodule
`default_nettype wire
